// ### bus_slave_model.sv
// Behavioural system-bus memory answering one beat at a time.
// Assumes the master holds each beat until bus_ack; latency set by lat.
`timescale 1ns/1ns
module bus_slave_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_seq,
  input wire logic bus_lock_out,
  input wire logic [3:0] lat,
  input wire logic err_en,
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  output logic bus_err
);
  // ----------------------------------------------------------------
  // Memory and traffic counters
  // ----------------------------------------------------------------
  logic [31:0] mem [logic [31:0]];
  logic [3:0] cnt;
  int rd_n = 0;
  int wr_n = 0;
  int lk_n = 0;
  int burst_n = 0;

  // Idle data toggles so a stale word never looks valid
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_ack <= 1'b0;
      bus_err <= 1'b0;
      bus_rdata <= 32'h00000000;
      cnt <= 4'h0;
    end else begin
      bus_ack <= 1'b0;
      bus_err <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (bus_req && !bus_ack) begin
        if (cnt < lat) cnt <= cnt + 4'h1;
        else begin
          cnt <= 4'h0;
          bus_ack <= 1'b1;
          bus_err <= err_en;
          if (!bus_seq) burst_n++;
          if (bus_lock_out) lk_n++;
          if (bus_write) begin
            mem[bus_addr] = bus_wdata;
            wr_n++;
          end else begin
            rd_n++;
            bus_rdata <= mem.exists(bus_addr) ? mem[bus_addr] : {bus_addr[15:0], ~bus_addr[15:0]};
          end
        end
      end
    end
  end
endmodule : bus_slave_model

// ### dcache_ctrl.sv
// Data-cache controller: lookup, linefill, victim write-back, write buffer,
// uncached bursts and swaps. Assumes the core holds its request until done
// and the bus slave answers each beat with one bus_ack pulse.
`timescale 1ns/1ns
module dcache_ctrl
  import dcache_pkg::*;
#(
  parameter int WB_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic core_req,
  input wire logic [31:0] core_addr,
  input wire logic core_write,
  input wire logic [1:0] core_size,
  input wire logic [31:0] core_wdata,
  input wire logic core_swap,
  input wire logic [4:0] core_count,
  input wire logic cachable,
  input wire logic bufferable,
  input wire logic replacement_select,
  input wire logic [5:0] lock_base,
  output logic core_done,
  output logic [31:0] core_rdata,
  output logic core_abort,
  output logic irq_hold,
  output logic bus_req,
  output logic bus_write,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata,
  output logic [3:0] bus_be,
  output logic bus_seq,
  output logic bus_lock_out,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_err
);

  localparam int PW = $clog2(WB_DEPTH);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte lanes touched by an access of the given size
  function automatic logic [3:0] be_of(input logic [1:0] sz, input logic [1:0] lo);
    logic [3:0] r;
    r = BE_ALL;
    if (sz == 2'h0) begin
      r = 4'(4'h1 << lo);
    end else if (sz == 2'h1) begin
      r = lo[1] ? 4'hC : 4'h3;
    end
    return r;
  endfunction : be_of

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8+:8] = n[b*8+:8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] data_ff [SEGS][LINES][WORDS];
  logic [24:0] tag_ff [SEGS][LINES];
  logic [LINES-1:0] valid_ff [SEGS];
  logic [1:0] dirty_ff [SEGS][LINES];
  logic [5:0] rr_ff [SEGS];
  logic [5:0] nxt_rr [SEGS];
  logic [31:0] wba_ff [WB_DEPTH];
  logic [31:0] wbd_ff [WB_DEPTH];
  logic [3:0] wbb_ff [WB_DEPTH];
  logic wbc_ff [WB_DEPTH];
  st_e st_ff, nxt_st;
  logic [3:0] beat_ff, nxt_beat, last_ff, nxt_last;
  logic [31:0] addr_ff, nxt_addr;
  logic [5:0] vic_ff, nxt_vic, lfsr_ff, nxt_lfsr;
  logic repl_ff;
  logic [PW-1:0] hd_ff, nxt_hd, tl_ff, nxt_tl;
  logic [PW:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done, abort_ff, nxt_abort, hold_ff, nxt_hold;
  logic [31:0] rdata_ff, nxt_rdata;
  logic req_ff, nxt_req, wr_ff, nxt_wr, seq_ff, nxt_seq, lock_ff, nxt_lock;
  logic main_ff, nxt_main;
  logic [31:0] baddr_ff, nxt_baddr, bdata_ff, nxt_bdata;
  logic [3:0] be_ff, nxt_be;

  // Lookup and write-port controls
  logic [1:0] seg;
  logic [24:0] tag;
  logic [2:0] wsel;
  logic hit, acc, wb_full, push, ack;
  logic [5:0] hidx, victim;
  logic [31:0] cur, push_a, push_d;
  logic [3:0] be, push_b;
  logic push_c, hit_we, fill_we, tag_we, dirty_we;

  assign seg = core_addr[SEG_HI:SEG_LO];
  assign tag = core_addr[31:TAG_LO];
  assign wsel = core_addr[WRD_HI:WRD_LO];
  assign be = be_of(core_size, core_addr[1:0]);
  assign wb_full = (cnt_ff == (PW+1)'(WB_DEPTH));
  assign ack = req_ff && bus_ack;
  assign acc = core_req && !done_ff;

  // ----------------------------------------------------------------
  // Lookup and victim choice
  // ----------------------------------------------------------------
  // Full compare across the segment; a CAM in silicon, costly but one cycle
  always_comb begin
    hit = 1'b0;
    hidx = 6'h00;
    for (int i = 0; i < LINES; i++) begin
      if (valid_ff[seg][i] && tag_ff[seg][i] == tag) begin
        hit = 1'b1;
        hidx = 6'(i);
      end
    end
    cur = data_ff[seg][hidx][wsel];
    if (repl_ff) begin
      victim = (rr_ff[seg] < lock_base) ? lock_base : rr_ff[seg];
    end else begin
      victim = (lfsr_ff < lock_base) ? lock_base : lfsr_ff;
    end
  end

  // ----------------------------------------------------------------
  // Controller next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_beat = beat_ff;
    nxt_last = last_ff;
    nxt_addr = addr_ff;
    nxt_vic = vic_ff;
    nxt_rr = rr_ff;
    nxt_lfsr = {lfsr_ff[4:0], lfsr_ff[5] ^ lfsr_ff[4]};
    nxt_done = 1'b0;
    nxt_abort = 1'b0;
    nxt_hold = hold_ff;
    nxt_rdata = rdata_ff;
    nxt_req = req_ff;
    nxt_wr = wr_ff;
    nxt_seq = seq_ff;
    nxt_lock = lock_ff;
    nxt_main = main_ff;
    nxt_baddr = baddr_ff;
    nxt_bdata = bdata_ff;
    nxt_be = be_ff;
    nxt_hd = hd_ff;
    push = 1'b0;
    push_a = {core_addr[31:2], 2'b00};
    push_d = core_wdata;
    push_b = be;
    push_c = 1'b0;
    hit_we = 1'b0;
    fill_we = 1'b0;
    tag_we = 1'b0;
    dirty_we = 1'b0;
    case (st_ff)
      S_IDLE: begin
        if (acc && cachable && hit && core_swap) begin
          nxt_rdata = cur;
          nxt_st = S_CSWP;
          nxt_hold = 1'b1;
        end else if (acc && cachable && hit && !core_write) begin
          nxt_rdata = cur;
          nxt_done = 1'b1;
        end else if (acc && cachable && hit && bufferable) begin
          hit_we = 1'b1;
          dirty_we = 1'b1;
          nxt_done = 1'b1;
        end else if (acc && cachable && hit && !wb_full) begin
          hit_we = 1'b1;
          push = 1'b1;
          nxt_done = 1'b1;
        end else if (acc && cachable && !hit && core_write && !core_swap) begin
          push = !wb_full;
          nxt_done = !wb_full;
        end else if (acc && cachable && !hit) begin
          nxt_rr[seg] = (victim == LAST_IDX) ? lock_base : 6'(victim + 6'h01);
          nxt_vic = victim;
          nxt_st = (dirty_ff[seg][victim] != 2'b00) ? S_PUSH : S_FILL;
          nxt_beat = dirty_ff[seg][victim][0] ? 4'h0 : HALF1_FIRST;
          nxt_last = dirty_ff[seg][victim][1] ? FILL_LAST : HALF0_LAST;
          if (nxt_st == S_FILL) begin
            nxt_beat = 4'h0;
          end
        end else if (acc && !cachable && core_write && !core_swap && bufferable) begin
          push = !wb_full;
          nxt_done = !wb_full;
        end else if (acc && !cachable) begin
          nxt_st = S_DRAIN;
          nxt_beat = 4'h0;
          nxt_last = core_swap ? 4'h0 : 4'(5'(core_count - 5'h01));
          nxt_addr = {core_addr[31:2], 2'b00};
        end
      end
      S_PUSH: begin
        push = !wb_full;
        push_a = {tag_ff[seg][vic_ff], seg, beat_ff[2:0], 2'b00};
        push_d = data_ff[seg][vic_ff][beat_ff[2:0]];
        push_b = BE_ALL;
        push_c = (beat_ff[1:0] != 2'b00) || (beat_ff == HALF1_FIRST && dirty_ff[seg][vic_ff][0]);
        if (!wb_full) begin
          nxt_beat = (beat_ff == last_ff) ? 4'h0 : 4'(beat_ff + 4'h1);
          nxt_st = (beat_ff == last_ff) ? S_FILL : S_PUSH;
        end
      end
      S_DRAIN: begin
        if (cnt_ff == '0 && !req_ff) begin
          nxt_st = S_UNC;
        end
      end
      S_CSWP: begin
        if (bufferable || !wb_full) begin
          hit_we = 1'b1;
          dirty_we = bufferable;
          push = !bufferable;
          nxt_done = 1'b1;
          nxt_hold = 1'b0;
          nxt_st = S_IDLE;
        end
      end
      default: begin
      end
    endcase
    // Bus beat start: main traffic first so a linefill overtakes queued write-backs;
    // a done pulse holds it off a cycle so the core can present its next store word
    if (!req_ff && !done_ff && (st_ff == S_FILL || st_ff == S_UNC || st_ff == S_SWPW)) begin
      nxt_req = 1'b1;
      nxt_main = 1'b1;
      nxt_baddr = (st_ff == S_FILL) ? {core_addr[31:5], beat_ff[2:0], 2'b00} : addr_ff;
      nxt_wr = (st_ff == S_SWPW) || (st_ff == S_UNC && core_write && !core_swap);
      nxt_bdata = core_wdata;
      nxt_be = (st_ff != S_FILL && last_ff == 4'h0) ? be : BE_ALL;
      nxt_seq = (beat_ff != 4'h0) && (nxt_baddr[KB_HI:0] != 10'h000);
      nxt_lock = core_swap && st_ff != S_FILL;
    end else if (!req_ff && cnt_ff != '0 && (st_ff != S_PUSH || wb_full)) begin
      nxt_req = 1'b1;
      nxt_main = 1'b0;
      nxt_baddr = wba_ff[hd_ff];
      nxt_bdata = wbd_ff[hd_ff];
      nxt_be = wbb_ff[hd_ff];
      nxt_wr = 1'b1;
      // split write-back bursts; a fill in between also restarts the burst
      nxt_seq = wbc_ff[hd_ff] && !main_ff && (wba_ff[hd_ff][KB_HI:0] != 10'h000);
      nxt_lock = 1'b0;
    end
    if (ack) begin
      nxt_req = 1'b0;
      nxt_seq = 1'b0;
      if (!main_ff) begin
        nxt_hd = PW'(hd_ff + 1'b1);
      end else if (st_ff == S_FILL) begin
        fill_we = 1'b1;
        tag_we = (beat_ff == FILL_LAST);
        nxt_beat = 4'(beat_ff + 4'h1);
        nxt_st = (beat_ff == FILL_LAST) ? S_IDLE : S_FILL;
      end else if (st_ff == S_UNC && core_swap) begin
        nxt_rdata = bus_rdata;
        nxt_st = S_SWPW;
      end else if (st_ff == S_UNC) begin
        nxt_done = 1'b1;
        nxt_abort = bus_err;
        nxt_rdata = core_write ? rdata_ff : bus_rdata;
        nxt_beat = 4'(beat_ff + 4'h1);
        nxt_addr = 32'(addr_ff + 32'h4);
        nxt_st = (beat_ff == last_ff) ? S_IDLE : S_UNC;
      end else begin
        nxt_done = 1'b1;
        nxt_abort = bus_err;
        nxt_lock = 1'b0;
        nxt_st = S_IDLE;
      end
    end
    nxt_tl = push ? PW'(tl_ff + 1'b1) : tl_ff;
    nxt_cnt = (PW+1)'(cnt_ff + (PW+1)'(push) - (PW+1)'(ack && !main_ff));
  end

  // Controller registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= S_IDLE;
      beat_ff <= 4'h0;
      last_ff <= 4'h0;
      addr_ff <= 32'h0;
      vic_ff <= 6'h00;
      rr_ff <= '{default: RR_RST};
      lfsr_ff <= LFSR_RST;
      repl_ff <= 1'b0;
      done_ff <= 1'b0;
      abort_ff <= 1'b0;
      hold_ff <= 1'b0;
      rdata_ff <= 32'h0;
      req_ff <= 1'b0;
      wr_ff <= 1'b0;
      seq_ff <= 1'b0;
      lock_ff <= 1'b0;
      main_ff <= 1'b0;
      baddr_ff <= 32'h0;
      bdata_ff <= 32'h0;
      be_ff <= 4'h0;
      hd_ff <= '0;
      tl_ff <= '0;
      cnt_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      beat_ff <= nxt_beat;
      last_ff <= nxt_last;
      addr_ff <= nxt_addr;
      vic_ff <= nxt_vic;
      rr_ff <= nxt_rr;
      lfsr_ff <= nxt_lfsr;
      repl_ff <= replacement_select;
      done_ff <= nxt_done;
      abort_ff <= nxt_abort;
      hold_ff <= nxt_hold;
      rdata_ff <= nxt_rdata;
      req_ff <= nxt_req;
      wr_ff <= nxt_wr;
      seq_ff <= nxt_seq;
      lock_ff <= nxt_lock;
      main_ff <= nxt_main;
      baddr_ff <= nxt_baddr;
      bdata_ff <= nxt_bdata;
      be_ff <= nxt_be;
      hd_ff <= nxt_hd;
      tl_ff <= nxt_tl;
      cnt_ff <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Data, tags and buffer words need no reset; valid gates data and tags, the entry count gates buffer words
  always_ff @(posedge sys_clk) begin
    if (hit_we) begin
      data_ff[seg][hidx][wsel] <= merge(cur, core_wdata, be);
    end
    if (fill_we) begin
      data_ff[seg][vic_ff][beat_ff[2:0]] <= bus_rdata;
    end
    if (tag_we) begin
      tag_ff[seg][vic_ff] <= tag;
    end
    if (push) begin
      wba_ff[tl_ff] <= push_a;
      wbd_ff[tl_ff] <= push_d;
      wbb_ff[tl_ff] <= push_b;
      wbc_ff[tl_ff] <= push_c;
    end
  end

  // Valid and dirty flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      valid_ff <= '{default: '0};
      dirty_ff <= '{default: 2'b00};
    end else begin
      if (fill_we) begin
        valid_ff[seg][vic_ff] <= 1'b0;
        dirty_ff[seg][vic_ff] <= 2'b00;
      end
      if (tag_we) begin
        valid_ff[seg][vic_ff] <= 1'b1;
      end
      if (dirty_we) begin
        dirty_ff[seg][hidx][wsel[2]] <= 1'b1;
      end
    end
  end

  // Outputs straight from flip-flops
  assign core_done = done_ff;
  assign core_rdata = rdata_ff;
  assign core_abort = abort_ff;
  assign irq_hold = hold_ff;
  assign bus_req = req_ff;
  assign bus_write = wr_ff;
  assign bus_addr = baddr_ff;
  assign bus_wdata = bdata_ff;
  assign bus_be = be_ff;
  assign bus_seq = seq_ff;
  assign bus_lock_out = lock_ff;

endmodule : dcache_ctrl

// ### dcache_ctrl_props.sv
// Concurrent checks on the data-cache controller's core and bus ports.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/1ns
module dcache_ctrl_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic core_write,
  input wire logic core_swap,
  input wire logic cachable,
  input wire logic bufferable,
  input wire logic core_done,
  input wire logic core_abort,
  input wire logic irq_hold,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic bus_seq,
  input wire logic bus_lock_out,
  input wire logic bus_ack
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic wr_ack_ff;
  logic [31:0] last_addr_ff;

  // Last acked address and a sticky write-ack flag cleared by each done that comes without a write ack in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ack_ff <= 1'b0;
      last_addr_ff <= 32'h00000000;
    end else begin
      if (bus_ack) last_addr_ff <= bus_addr;
      if (bus_ack && bus_write) wr_ack_ff <= 1'b1;
      else if (core_done) wr_ack_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_seq_step;
    bus_req && bus_seq |-> bus_addr == last_addr_ff + 32'h00000004;
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("burst beat not consecutive");
  property p_kb_split;
    bus_req && bus_addr[9:0] == 10'h000 |-> !bus_seq;
  endproperty
  a_kb_split: assert property (p_kb_split) else $error("burst crosses 1KB");
  property p_fill_start;
    bus_req && !bus_write && cachable |-> bus_seq == (bus_addr[4:2] != 3'h0);
  endproperty
  a_fill_start: assert property (p_fill_start) else $error("fill not line burst");
  property p_hold;
    bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_write);
  endproperty
  a_hold: assert property (p_hold) else $error("bus beat changed early");
  property p_ack_drop;
    bus_ack |=> !bus_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");
  property p_lock_src;
    bus_req && bus_lock_out |-> core_swap && !cachable;
  endproperty
  a_lock_src: assert property (p_lock_src) else $error("lock outside uncached swap");
  property p_lock_span;
    bus_req && !bus_write && bus_lock_out |-> ##[1:200] (bus_req && bus_write && bus_lock_out);
  endproperty
  a_lock_span: assert property (p_lock_span) else $error("locked write missing");
  property p_irq_src;
    irq_hold |-> core_swap && cachable;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq hold outside swap");
  property p_no_abort;
    core_done && cachable |-> !core_abort;
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("cached abort reported");
  property p_stall;
    core_done && !cachable && !bufferable && core_write && !core_swap |-> wr_ack_ff;
  endproperty
  a_stall: assert property (p_stall) else $error("write done before bus ack");

  c_fill: cover property (bus_ack && cachable && bus_seq);
  c_lock: cover property (bus_ack && bus_write && bus_lock_out);
  c_irq: cover property (irq_hold);
endmodule : dcache_ctrl_props

bind dcache_ctrl dcache_ctrl_props dcache_ctrl_props_inst (
  .sys_clk(sys_clk), .rst(rst), .core_write(core_write), .core_swap(core_swap),
  .cachable(cachable), .bufferable(bufferable), .core_done(core_done),
  .core_abort(core_abort), .irq_hold(irq_hold), .bus_req(bus_req), .bus_write(bus_write),
  .bus_addr(bus_addr), .bus_seq(bus_seq), .bus_lock_out(bus_lock_out), .bus_ack(bus_ack)
);

// ### dcache_pkg.sv
// Shared constants for the data-cache fill, write-back and swap block.
// Assumes a 32-bit byte-addressed core and a single-beat system bus.
package dcache_pkg;

  // ----------------------------------------------------------------
  // Geometry and address slicing
  // ----------------------------------------------------------------
  localparam int SEGS = 4;
  localparam int LINES = 64;
  localparam int WORDS = 8;
  localparam int TAG_LO = 7;
  localparam int SEG_HI = 6;
  localparam int SEG_LO = 5;
  localparam int WRD_HI = 4;
  localparam int WRD_LO = 2;
  localparam int KB_HI = 9;

  // ----------------------------------------------------------------
  // Reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [5:0] RR_RST = 6'h00;
  localparam logic [5:0] LFSR_RST = 6'h01;
  localparam logic [5:0] LAST_IDX = 6'h3F;
  localparam logic [3:0] BE_ALL = 4'hF;
  localparam logic [3:0] FILL_LAST = 4'h7;
  localparam logic [3:0] HALF1_FIRST = 4'h4;
  localparam logic [3:0] HALF0_LAST = 4'h3;

  // Main controller states
  typedef enum logic [2:0] {
    S_IDLE, S_PUSH, S_FILL, S_DRAIN, S_UNC, S_SWPW, S_CSWP
  } st_e;

endpackage : dcache_pkg

// ### tb_top.sv
// Self-checking bench for the data-cache controller with a bus memory model.
// Assumes the controller's hand-over timing: request held until done.
`timescale 1ns/1ns
module tb_top;
  // ----------------------------------------------------------------
  // Stimulus, wiring and bookkeeping
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0, rst = 1'b1, core_req = 1'b0, core_write = 1'b0, core_swap = 1'b0;
  logic cachable = 1'b0, bufferable = 1'b0, replacement_select = 1'b0, err_en = 1'b0;
  logic [31:0] core_addr = 32'h00000000, core_wdata = 32'h00000000, rd;
  logic [1:0] core_size = 2'h2;
  logic [4:0] core_count = 5'h01;
  logic [5:0] lock_base = 6'h00;
  logic [3:0] lat = 4'h0;
  logic core_done, core_abort, irq_hold, bus_req, bus_write, bus_seq, bus_lock_out;
  logic bus_ack, bus_err, ab, irq_seen;
  logic [31:0] core_rdata, bus_addr, bus_wdata, bus_rdata;
  logic [3:0] bus_be;
  int fail_count = 0, compares = 0, w0, r0, l0, b0;

  dcache_ctrl #(.WB_DEPTH(8)) dcache_ctrl_inst (.*);
  bus_slave_model bus_slave_model_inst (.*);

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (irq_hold === 1'b1) irq_seen <= 1'b1;

  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction : pat

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One core access; multi-word accesses finish one beat per done
  task automatic acc(input logic [31:0] a, input logic w, sw, c, b, input logic [31:0] d,
                     input int n);
    int t;
    @(posedge sys_clk);
    core_addr <= a;
    core_write <= w;
    core_swap <= sw;
    cachable <= c;
    bufferable <= b;
    core_wdata <= d;
    core_count <= n[4:0];
    core_req <= 1'b1;
    for (int k = 0; k < n; k++) begin
      t = 0;
      do begin
        @(posedge sys_clk);
        t++;
      end while (core_done !== 1'b1 && t < 400);
      if (t >= 400) check(1'b0, 1'b1);
      rd = core_rdata;
      ab = core_abort;
      core_wdata <= d + 32'(k + 1);
    end
    core_req <= 1'b0;
  endtask : acc

  // Write-back traffic drains after the core resumes, so wait on the count
  task automatic waitw(input int n);
    int t;
    t = 0;
    while (bus_slave_model_inst.wr_n < n && t < 300) begin
      @(posedge sys_clk);
      t++;
    end
    check(bus_slave_model_inst.wr_n, n);
  endtask : waitw

  task automatic t_fill;
    r0 = bus_slave_model_inst.rd_n;
    acc(32'h10000048, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0, 1);
    check(rd, pat(32'h10000048));
    check(bus_slave_model_inst.rd_n, r0 + 8);
    acc(32'h1000005C, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0, 1);
    check(rd, pat(32'h1000005C));
    check(bus_slave_model_inst.rd_n, r0 + 8);
    acc(32'h20000048, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0, 1);
    check(bus_slave_model_inst.rd_n, r0 + 16);
  endtask : t_fill

  // Only lines 62 and 63 are replaceable, so the third fill evicts the first
  task automatic t_evict;
    @(posedge sys_clk);
    replacement_select <= 1'b1;
    lock_base <= 6'h3E;
    w0 = bus_slave_model_inst.wr_n;
    r0 = bus_slave_model_inst.rd_n;
    acc(32'h30000020, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0, 1);
    acc(32'h30000024, 1'b1, 1'b0, 1'b1, 1'b1, 32'hCAFE0001, 1);
    check(bus_slave_model_inst.wr_n, w0);
    acc(32'h31000020, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0, 1);
    acc(32'h31000020, 1'b1, 1'b0, 1'b1, 1'b1, 32'h000000B0, 1);
    acc(32'h31000030, 1'b1, 1'b0, 1'b1, 1'b1, 32'h000000B1, 1);
    acc(32'h32000020, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0, 1);
    waitw(w0 + 4);
    check(bus_slave_model_inst.mem[32'h30000024], 32'hCAFE0001);
    acc(32'h30000020, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0, 1);
    check(rd, pat(32'h30000020));
    waitw(w0 + 12);
    check(bus_slave_model_inst.mem[32'h31000030], 32'h000000B1);
    check(bus_slave_model_inst.rd_n, r0 + 32);
  endtask : t_evict

  task automatic t_wbmiss;
    w0 = bus_slave_model_inst.wr_n;
    err_en <= 1'b1;
    acc(32'h40000044, 1'b1, 1'b0, 1'b1, 1'b1, 32'h00001234, 1);
    check(ab, 1'b0);
    waitw(w0 + 1);
    err_en <= 1'b0;
    r0 = bus_slave_model_inst.rd_n;
    acc(32'h40000044, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0, 1);
    check(rd, 32'h00001234);
    check(bus_slave_model_inst.rd_n, r0 + 8);
  endtask : t_wbmiss

  task automatic t_burst;
    b0 = bus_slave_model_inst.burst_n;
    acc(32'h000003F8, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 4);
    check(rd, pat(32'h00000404));
    check(bus_slave_model_inst.burst_n, b0 + 2);
    acc(32'h500007FC, 1'b1, 1'b0, 1'b0, 1'b0, 32'h00000A00, 2);
    check(bus_slave_model_inst.mem[32'h50000800], 32'h00000A01);
    check(bus_slave_model_inst.burst_n, b0 + 4);
  endtask : t_burst

  task automatic t_swaps;
    lat <= 4'h3;
    l0 = bus_slave_model_inst.lk_n;
    acc(32'h60000000, 1'b1, 1'b0, 1'b0, 1'b1, 32'h00000055, 1);
    acc(32'h60000100, 1'b0, 1'b1, 1'b0, 1'b1, 32'h00000077, 1);
    check(bus_slave_model_inst.mem[32'h60000000], 32'h00000055);
    check(bus_slave_model_inst.mem[32'h60000100], 32'h00000077);
    check(rd, pat(32'h60000100));
    check(bus_slave_model_inst.lk_n, l0 + 2);
    irq_seen <= 1'b0;
    acc(32'h10000048, 1'b0, 1'b1, 1'b1, 1'b1, 32'h00000099, 1);
    check(rd, pat(32'h10000048));
    check(irq_seen, 1'b1);
    acc(32'h10000048, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0, 1);
    check(rd, 32'h00000099);
    check(bus_slave_model_inst.lk_n, l0 + 2);
    core_size <= 2'h0;
    acc(32'h1000004A, 1'b1, 1'b0, 1'b1, 1'b1, 32'h00AB0000, 1);
    core_size <= 2'h2;
    acc(32'h10000048, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0, 1);
    check(rd, 32'h00AB0099);
  endtask : t_swaps

  task automatic report_and_stop;
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  // Bound well above the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("ERROR %0t: watchdog expired", $time);
    report_and_stop;
  end

  initial begin
    irq_seen = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_fill;
    t_evict;
    t_wbmiss;
    t_burst;
    t_swaps;
    report_and_stop;
  end
endmodule : tb_top
